/* File: batt_status_pkg.sv */
// constants, field layouts and carriers for the battery status word bank
// assumes every measurement and threshold arrives from gauge logic on the same clock
package batt_status_pkg;

	// ****************************************************************
	// command codes
	// ****************************************************************
	localparam logic [7:0] CMD_AVG_EMPTY = 8'h12;
	localparam logic [7:0] CMD_AVG_FULL = 8'h13;
	localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
	localparam logic [7:0] CMD_STATUS = 8'h16;

	// ****************************************************************
	// status word bit positions
	// ****************************************************************
	localparam int BIT_OVER_CHARGED = 15;
	localparam int BIT_TERM_CHARGE = 14;
	localparam int BIT_OVER_TEMP = 12;
	localparam int BIT_TERM_DISCHARGE = 11;
	localparam int BIT_LOW_CHARGE = 9;
	localparam int BIT_LOW_RUNTIME = 8;
	localparam int BIT_INITIALIZED = 7;
	localparam int BIT_DISCHARGING = 6;
	localparam int BIT_FULLY_CHARGED = 5;
	localparam int BIT_FULLY_DISCHARGED = 4;
	localparam int ERR_W = 3;

	// ****************************************************************
	// error codes
	// ****************************************************************
	localparam logic [2:0] ERR_OK = 3'h0;
	localparam logic [2:0] ERR_BUSY = 3'h1;
	localparam logic [2:0] ERR_RESERVED_CMD = 3'h2;
	localparam logic [2:0] ERR_UNSUPPORTED = 3'h3;
	localparam logic [2:0] ERR_ACCESS_DENIED = 3'h4;
	localparam logic [2:0] ERR_OVERFLOW = 3'h5;
	localparam logic [2:0] ERR_BAD_SIZE = 3'h6;
	localparam logic [2:0] ERR_UNKNOWN = 3'h7;

	// ****************************************************************
	// values and counts
	// ****************************************************************
	localparam logic [15:0] WORD_INVALID = 16'hFFFF;
	localparam logic [15:0] MINUTES_MAX = 16'hFFFE;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [1:0] OVERCHG_CLEAR_MAH = 2'h2;
	localparam logic [7:0] FULLY_DIS_CLEAR_PCT = 8'h14;
	localparam logic [4:0] DIV_STEPS = 5'h18;
	localparam logic [7:0] MINUTES_PER_HOUR = 8'h3C;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [15:0] remaining_charge;
		logic [15:0] full_charge;
		logic signed [15:0] smoothed_current;
		logic signed [15:0] smoothed_power;
		logic signed [15:0] instant_current;
		logic [15:0] pack_voltage;
		logic [15:0] single_cell_voltage;
		logic signed [15:0] temperature;
		logic [7:0] charge_percent_of_full;
		logic charging;
		logic cell_undervoltage_flag;
	} gauge_meas_t;

	typedef struct packed {
		logic [15:0] overcharge_margin;
		logic [15:0] terminate_voltage;
		logic signed [15:0] suspend_temp_low;
		logic signed [15:0] ot_charge_set;
		logic signed [15:0] ot_charge_reset;
		logic signed [15:0] ot_discharge_set;
		logic signed [15:0] ot_discharge_reset;
		logic [15:0] end_voltage_level_two;
		logic [15:0] end_voltage_level_two_cell;
		logic [15:0] overload_current;
		logic [7:0] full_clear_pct;
		logic [7:0] low_pct;
		logic [15:0] low_charge_threshold;
		logic [15:0] low_runtime_threshold;
	} gauge_cfg_t;

	typedef enum logic [2:0] {
		DIV_IDLE = 3'b001,
		DIV_RUN = 3'b010,
		DIV_STORE = 3'b100
	} div_state_t;

endpackage : batt_status_pkg

/* File: battery_status_word_logic.sv */
// battery status word bank: time estimates, charge requests, alarm and status flags
// assumes a word-read front end that presents a command code with one-cycle strobes
`timescale 1ns/1ps

// Contract
// - code 0x12 returns averaged minutes to empty, 0..65534; 65535 when not discharging.
// - code 0x13 returns averaged minutes to full; 65535 when not charging.
// - code 0x14 returns requested charge current in mA; zero turns charger off.
// - code 0x15 returns requested charge voltage in mV; 65535 means constant-current.
// - status word alarm bits at 0x8000..0x0100; 0x2000 and 0x0400 reserved.
// - status bits: initialized, discharging, fully charged, fully discharged.
// - low three status bits hold the error code of the last transaction.
// - alarm broadcast sends the status word with error-code bits all ones.
// - overcharge sets above full plus margin; clears after 2 mAh non-charging.
// - end-of-charge sets on charge termination; clears when charging stops.
// - over-temperature uses charge or discharge thresholds with matching resets.
// - end-of-discharge sets on four conditions; clears when voltage, charge, undervoltage recover.
// - low-capacity alarm compares remaining charge with host capacity threshold.
// - low-run-time alarm compares time to empty with host time threshold.
// - initialized bit follows valid or improper data-flash load.
// - discharging bit is set whenever the battery is not charging.
// - fully-charged sets on termination or overcharge; clears below clear percentage.
// - fully-discharged sets on low voltage or low percent; clears at 20 percent.
// - time estimates use current or power as the capacity-unit mode selects.
// - averaged time estimates have granularity of two minutes or better.
// - capacity mode 0 means mAh, mode 1 means 10 mWh units.
module battery_status_word_logic (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic srst_in,
	// word command port
	input wire logic [7:0] cmd_code_in,
	input wire logic cmd_read_in,
	input wire logic cmd_write_in,
	input wire logic cmd_bad_size_in,
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	// alarm broadcast
	input wire logic alarm_send_in,
	output logic [15:0] alarm_broadcast_message_out,
	output logic alarm_valid_out,
	// gauge measurements and configuration
	input wire batt_status_pkg::gauge_meas_t meas_in,
	input wire batt_status_pkg::gauge_cfg_t cfg_in,
	input wire logic capacity_mode_in,
	input wire logic [15:0] req_current_in,
	input wire logic [15:0] req_voltage_in,
	// events from the gauge
	input wire logic charge_term_in,
	input wire logic non_charge_mah_in,
	input wire logic flash_load_ok_in,
	input wire logic flash_load_bad_in,
	// charger hint
	output logic charger_off_out
);

	// ****************************************************************
	// time estimate divider
	// ****************************************************************
	batt_status_pkg::div_state_t st_q;
	logic for_full_q;
	logic [23:0] dvd_q;
	logic [16:0] rem_q;
	logic [15:0] dvs_q;
	logic [4:0] step_q;
	logic valid_est_q;
	logic [15:0] avg_empty_q;
	logic [15:0] avg_full_q;

	// mode 0 works in mAh over mA, mode 1 in 10 mWh over 10 mW
	wire logic signed [15:0] rate = capacity_mode_in ? meas_in.smoothed_power :
		meas_in.smoothed_current;
	wire logic discharging_rate = rate < 16'sh0000;
	wire logic charging_rate = rate > 16'sh0000;
	wire logic [15:0] rate_mag = discharging_rate ? 16'(-rate) : 16'(rate);
	wire logic [15:0] to_full = (meas_in.full_charge > meas_in.remaining_charge) ?
		16'(meas_in.full_charge - meas_in.remaining_charge) : 16'h0000;
	wire logic [15:0] amount = for_full_q ? to_full : meas_in.remaining_charge;
	// amount * 60 fits in 22 bits; one-minute resolution beats the granularity
	wire logic [23:0] amount_min = 24'(amount) * 24'(batt_status_pkg::MINUTES_PER_HOUR);
	wire logic [16:0] trial = {rem_q[15:0], dvd_q[23]};
	wire logic fits = trial >= {1'b0, dvs_q};
	wire logic [16:0] rem_next = fits ? 17'(trial - {1'b0, dvs_q}) : trial;
	wire logic over_range = (dvd_q[23:16] != 8'h00) || (dvd_q[15:0] > batt_status_pkg::MINUTES_MAX);
	wire logic [15:0] quotient_sat = over_range ? batt_status_pkg::MINUTES_MAX : dvd_q[15:0];

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			st_q <= batt_status_pkg::DIV_IDLE;
			for_full_q <= 1'b0;
			dvd_q <= 24'h000000;
			rem_q <= 17'h00000;
			dvs_q <= 16'h0000;
			step_q <= 5'h00;
		end else begin
			case (st_q)
				batt_status_pkg::DIV_IDLE: begin
					dvd_q <= amount_min;
					rem_q <= 17'h00000;
					dvs_q <= rate_mag;
					valid_est_q <= for_full_q ? charging_rate : discharging_rate;
					step_q <= 5'h00;
					st_q <= batt_status_pkg::DIV_RUN;
				end
				batt_status_pkg::DIV_RUN: begin
					dvd_q <= {dvd_q[22:0], fits};
					rem_q <= rem_next;
					step_q <= 5'(step_q + 5'h01);
					if (step_q == 5'(batt_status_pkg::DIV_STEPS - 5'h01)) begin
						st_q <= batt_status_pkg::DIV_STORE;
					end
				end
				batt_status_pkg::DIV_STORE: begin
					for_full_q <= ~for_full_q;
					st_q <= batt_status_pkg::DIV_IDLE;
				end
				default: begin
					st_q <= batt_status_pkg::DIV_IDLE;
				end
			endcase
		end
	end

	// a zero rate never counts as valid, so the divide-by-zero result is never stored
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			avg_empty_q <= batt_status_pkg::WORD_INVALID;
			avg_full_q <= batt_status_pkg::WORD_INVALID;
		end else if (st_q == batt_status_pkg::DIV_STORE) begin
			if (for_full_q) begin
				avg_full_q <= valid_est_q ? quotient_sat : batt_status_pkg::WORD_INVALID;
			end else begin
				avg_empty_q <= valid_est_q ? quotient_sat : batt_status_pkg::WORD_INVALID;
			end
		end
	end

	// ****************************************************************
	// charge requests
	// ****************************************************************
	logic [15:0] req_current_q;
	logic [15:0] req_voltage_q;

	// values pass unchanged, so 0 and 65535 keep their meaning for the charger
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			req_current_q <= batt_status_pkg::WORD_RESET;
			req_voltage_q <= batt_status_pkg::WORD_RESET;
			charger_off_out <= 1'b1;
		end else begin
			req_current_q <= req_current_in;
			req_voltage_q <= req_voltage_in;
			charger_off_out <= req_current_in == 16'h0000;
		end
	end

	// ****************************************************************
	// alarm and status flags
	// ****************************************************************
	logic over_charged_q;
	logic term_charge_q;
	logic over_temp_q;
	logic term_discharge_q;
	logic low_charge_q;
	logic low_runtime_q;
	logic initialized_q;
	logic discharging_q;
	logic fully_charged_q;
	logic fully_discharged_q;
	logic [1:0] nc_mah_q;
	logic [15:0] rm_prev_q;

	wire logic chg = meas_in.charging;
	wire logic overcharge_cond = chg && ({1'b0, meas_in.remaining_charge} >
		17'(meas_in.full_charge + cfg_in.overcharge_margin));
	wire logic nc_done = !chg && non_charge_mah_in &&
		(nc_mah_q == 2'(batt_status_pkg::OVERCHG_CLEAR_MAH - 2'h1));
	wire logic ot_set = chg ? (meas_in.temperature >= cfg_in.ot_charge_set) :
		(meas_in.temperature >= cfg_in.ot_discharge_set);
	wire logic ot_clr = chg ? (meas_in.temperature < cfg_in.ot_charge_reset) :
		(meas_in.temperature < cfg_in.ot_discharge_reset);
	wire logic eod_set = (meas_in.remaining_charge == 16'h0000) ||
		(meas_in.pack_voltage <= cfg_in.terminate_voltage) ||
		(meas_in.temperature <= cfg_in.suspend_temp_low) || meas_in.cell_undervoltage_flag;
	wire logic eod_clr = (meas_in.pack_voltage > cfg_in.terminate_voltage) &&
		(meas_in.remaining_charge != 16'h0000) && !meas_in.cell_undervoltage_flag;
	wire logic lc_set = meas_in.remaining_charge < cfg_in.low_charge_threshold;
	wire logic lc_clr = (cfg_in.low_charge_threshold < meas_in.remaining_charge) ||
		(chg && (meas_in.remaining_charge > rm_prev_q));
	wire logic lt_set = avg_empty_q < cfg_in.low_runtime_threshold;
	wire logic lt_clr = (cfg_in.low_runtime_threshold < avg_empty_q) || chg;
	wire logic fc_set = charge_term_in || overcharge_cond;
	wire logic fc_clr = meas_in.charge_percent_of_full < cfg_in.full_clear_pct;
	wire logic fd_set = (((meas_in.pack_voltage < cfg_in.end_voltage_level_two) ||
		(meas_in.single_cell_voltage < cfg_in.end_voltage_level_two_cell)) &&
		(meas_in.instant_current < $signed(cfg_in.overload_current))) ||
		(meas_in.charge_percent_of_full < cfg_in.low_pct);
	wire logic fd_clr = meas_in.charge_percent_of_full >= batt_status_pkg::FULLY_DIS_CLEAR_PCT;

	// non-charging mAh quanta count only while not charging; charging restarts the count
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || chg || !over_charged_q) begin
			nc_mah_q <= 2'h0;
		end else if (non_charge_mah_in && !nc_done) begin
			nc_mah_q <= 2'(nc_mah_q + 2'h1);
		end
	end

	// every set term is tested before its clear, so a coinciding event is kept
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			over_charged_q <= 1'b0;
			term_charge_q <= 1'b0;
			over_temp_q <= 1'b0;
			term_discharge_q <= 1'b0;
			low_charge_q <= 1'b0;
			low_runtime_q <= 1'b0;
			discharging_q <= 1'b1;
			fully_charged_q <= 1'b0;
			fully_discharged_q <= 1'b0;
			rm_prev_q <= 16'h0000;
		end else begin
			rm_prev_q <= meas_in.remaining_charge;
			over_charged_q <= overcharge_cond || (over_charged_q && !nc_done);
			term_charge_q <= charge_term_in || (term_charge_q && chg);
			over_temp_q <= ot_set || (over_temp_q && !ot_clr);
			term_discharge_q <= eod_set || (term_discharge_q && !eod_clr);
			low_charge_q <= lc_set || (low_charge_q && !lc_clr);
			low_runtime_q <= lt_set || (low_runtime_q && !lt_clr);
			discharging_q <= !chg;
			fully_charged_q <= fc_set || (fully_charged_q && !fc_clr);
			fully_discharged_q <= fd_set || (fully_discharged_q && !fd_clr);
		end
	end

	// a valid load wins over a simultaneous improper one
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			initialized_q <= 1'b0;
		end else begin
			initialized_q <= flash_load_ok_in || (initialized_q && !flash_load_bad_in);
		end
	end

	// ****************************************************************
	// status word and command handling
	// ****************************************************************
	logic [2:0] err_q;

	wire logic [15:0] status_word = {over_charged_q, term_charge_q, 1'b0, over_temp_q,
		term_discharge_q, 1'b0, low_charge_q, low_runtime_q, initialized_q,
		discharging_q, fully_charged_q, fully_discharged_q, 1'b0, err_q};
	wire logic cmd_known = (cmd_code_in >= batt_status_pkg::CMD_AVG_EMPTY) &&
		(cmd_code_in <= batt_status_pkg::CMD_STATUS);
	wire logic [2:0] err_next = !cmd_known ? batt_status_pkg::ERR_UNSUPPORTED :
		cmd_write_in ? (cmd_bad_size_in ? batt_status_pkg::ERR_BAD_SIZE :
		batt_status_pkg::ERR_ACCESS_DENIED) : batt_status_pkg::ERR_OK;
	wire logic [15:0] rd_mux = (cmd_code_in == batt_status_pkg::CMD_AVG_EMPTY) ? avg_empty_q :
		(cmd_code_in == batt_status_pkg::CMD_AVG_FULL) ? avg_full_q :
		(cmd_code_in == batt_status_pkg::CMD_CHG_CURRENT) ? req_current_q :
		(cmd_code_in == batt_status_pkg::CMD_CHG_VOLTAGE) ? req_voltage_q :
		(cmd_code_in == batt_status_pkg::CMD_STATUS) ? status_word : 16'h0000;

	// a status read shows the previous transaction's code, then records its own
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			err_q <= batt_status_pkg::ERR_OK;
			rd_data_out <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= cmd_read_in;
			if (cmd_read_in) begin
				rd_data_out <= rd_mux;
			end
			if (cmd_read_in || cmd_write_in) begin
				err_q <= err_next;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			alarm_broadcast_message_out <= 16'h0000;
			alarm_valid_out <= 1'b0;
		end else begin
			alarm_valid_out <= alarm_send_in;
			if (alarm_send_in) begin
				alarm_broadcast_message_out <= {status_word[15:3], 3'h7};
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_empty_invalid;
		@(posedge ref_clk_in) disable iff (srst_in)
		(st_q == batt_status_pkg::DIV_STORE && !for_full_q && !valid_est_q) |=>
		avg_empty_q == 16'hFFFF;
	endproperty
	a_empty_invalid: assert property (p_empty_invalid) else $error("empty time not invalid");

	property p_full_invalid;
		@(posedge ref_clk_in) disable iff (srst_in)
		(st_q == batt_status_pkg::DIV_STORE && for_full_q && !valid_est_q) |=>
		avg_full_q == 16'hFFFF;
	endproperty
	a_full_invalid: assert property (p_full_invalid) else $error("full time not invalid");

	property p_empty_range;
		@(posedge ref_clk_in) disable iff (srst_in)
		(st_q == batt_status_pkg::DIV_STORE && !for_full_q && valid_est_q) |=>
		avg_empty_q <= 16'hFFFE;
	endproperty
	a_empty_range: assert property (p_empty_range) else $error("empty time out of range");

	property p_read_current;
		@(posedge ref_clk_in) disable iff (srst_in)
		(cmd_read_in && cmd_code_in == 8'h14) |=> rd_valid_out && rd_data_out == $past(req_current_q);
	endproperty
	a_read_current: assert property (p_read_current) else $error("current read wrong");

	property p_alarm_err_ones;
		@(posedge ref_clk_in) disable iff (srst_in)
		alarm_send_in |=> alarm_valid_out && alarm_broadcast_message_out[2:0] == 3'h7 &&
		alarm_broadcast_message_out[15:3] == $past(status_word[15:3]);
	endproperty
	a_alarm_err_ones: assert property (p_alarm_err_ones) else $error("broadcast code not ones");

	property p_reserved_zero;
		@(posedge ref_clk_in) disable iff (srst_in)
		rd_valid_out |-> !((rd_data_out[13] || rd_data_out[10] || rd_data_out[3]) &&
		$past(cmd_code_in) == 8'h16);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_eoc_clear;
		@(posedge ref_clk_in) disable iff (srst_in)
		(!chg && !charge_term_in) ##1 (!chg && !charge_term_in) |-> !term_charge_q;
	endproperty
	a_eoc_clear: assert property (p_eoc_clear) else $error("end of charge stuck");

	property p_eod_set;
		@(posedge ref_clk_in) disable iff (srst_in)
		(meas_in.remaining_charge == 16'h0000) |=> term_discharge_q;
	endproperty
	a_eod_set: assert property (p_eod_set) else $error("end of discharge missed");

	property p_discharging;
		@(posedge ref_clk_in) disable iff (srst_in)
		1'b1 |=> discharging_q == !$past(chg);
	endproperty
	a_discharging: assert property (p_discharging) else $error("discharging bit wrong");

	property p_err_unsupported;
		@(posedge ref_clk_in) disable iff (srst_in)
		(cmd_read_in && (cmd_code_in < 8'h12 || cmd_code_in > 8'h16)) |=> err_q == 3'h3;
	endproperty
	a_err_unsupported: assert property (p_err_unsupported) else $error("bad error code");

	property p_fd_clear;
		@(posedge ref_clk_in) disable iff (srst_in)
		(!fd_set && meas_in.charge_percent_of_full >= 8'h14) |=> !fully_discharged_q;
	endproperty
	a_fd_clear: assert property (p_fd_clear) else $error("fully discharged stuck");

endmodule : battery_status_word_logic

/* File: batt_host_model.sv */
// host and charger model facing the command port of the status word bank
// assumes the bench calls its tasks at a falling edge of ref_clk_in
`timescale 1ns/1ps
module batt_host_model (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic srst_in,
	// answers from the gauge
	input wire logic [15:0] rd_data_in,
	input wire logic rd_valid_in,
	// command strobes toward the gauge
	output logic [7:0] cmd_code_out,
	output logic cmd_read_out,
	output logic cmd_write_out,
	output logic cmd_bad_size_out,
	// charger operating mode taken from the last request words
	output logic cv_mode_out,
	output logic cc_mode_out
);
	// ****************************************************************
	// word transactions
	// ****************************************************************
	initial begin
		cmd_code_out = 8'h00;
		cmd_read_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_bad_size_out = 1'b0;
		cv_mode_out = 1'b0;
		cc_mode_out = 1'b0;
	end
	// the answer is sought for a few cycles only, so a silent gauge cannot hang the run
	task automatic read_word(input logic [7:0] code, output logic [15:0] data, output bit ok);
		ok = 1'b0;
		data = 16'h0000;
		cmd_code_out = code;
		cmd_read_out = 1'b1;
		@(negedge ref_clk_in);
		cmd_read_out = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				data = rd_data_in;
				ok = 1'b1;
			end else begin
				@(negedge ref_clk_in);
			end
		end
		if (code == batt_status_pkg::CMD_CHG_CURRENT)
			cv_mode_out = (data === batt_status_pkg::WORD_INVALID);
		if (code == batt_status_pkg::CMD_CHG_VOLTAGE)
			cc_mode_out = (data === batt_status_pkg::WORD_INVALID);
		// one idle cycle, so a following call never re-raises the strobe it just lowered
		@(negedge ref_clk_in);
	endtask : read_word
	task automatic write_word(input logic [7:0] code, input logic bad);
		cmd_code_out = code;
		cmd_write_out = 1'b1;
		cmd_bad_size_out = bad;
		@(negedge ref_clk_in);
		cmd_write_out = 1'b0;
		cmd_bad_size_out = 1'b0;
	endtask : write_word
endmodule : batt_host_model

/* File: tb.sv */
// self-checking bench for the battery status word bank
// assumes the host model owns the command port and the bench owns the gauge inputs
`timescale 1ns/1ps
module tb;
	logic ref_clk, srst, cap_mode, rd_valid, msg_valid, chg_off, cv, cc;
	logic [4:0] ev;
	logic [15:0] req_i, req_v, rd_data, msg, d;
	logic [7:0] code;
	logic rd_s, wr_s, bad_s;
	batt_status_pkg::gauge_meas_t m;
	batt_status_pkg::gauge_cfg_t c;
	int num_errors = 0;
	int num_checks = 0;
	battery_status_word_logic i_battery_status_word_logic (.ref_clk_in(ref_clk), .srst_in(srst),
		.cmd_code_in(code), .cmd_read_in(rd_s), .cmd_write_in(wr_s), .cmd_bad_size_in(bad_s),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .alarm_send_in(ev[4]),
		.alarm_broadcast_message_out(msg), .alarm_valid_out(msg_valid), .meas_in(m),
		.cfg_in(c), .capacity_mode_in(cap_mode), .req_current_in(req_i), .req_voltage_in(req_v),
		.charge_term_in(ev[0]), .non_charge_mah_in(ev[1]), .flash_load_ok_in(ev[2]),
		.flash_load_bad_in(ev[3]), .charger_off_out(chg_off));
	batt_host_model i_batt_host_model (.ref_clk_in(ref_clk), .srst_in(srst), .rd_data_in(rd_data),
		.rd_valid_in(rd_valid), .cmd_code_out(code), .cmd_read_out(rd_s), .cmd_write_out(wr_s),
		.cmd_bad_size_out(bad_s), .cv_mode_out(cv), .cc_mode_out(cc));
	// ****************************************************************
	// helpers
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task tally_and_finish;
		if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task rd(input logic [7:0] a, output logic [15:0] q);
		bit ok;
		i_batt_host_model.read_word(a, q, ok);
		if (!ok) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : rd
	task rdc(input logic [7:0] a, input logic [15:0] e);
		rd(a, d);
		check(d, e);
	endtask : rdc
	// one idle cycle first so that a flag changed at this edge has landed
	task st(input logic [15:0] mk, input logic [15:0] e);
		@(negedge ref_clk);
		rd(8'h16, d);
		check(d & mk, e);
	endtask : st
	task pulse(input int i);
		ev[i] = 1'b1;
		@(negedge ref_clk);
		ev[i] = 1'b0;
	endtask : pulse
	// a stale divider round plus two fresh ones of 26 cycles each, with margin
	task settle;
		repeat (80) @(negedge ref_clk);
	endtask : settle
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset;
		rdc(8'h12, 16'hFFFF);
		rdc(8'h13, 16'hFFFF);
		st(16'hFFFF, 16'h0040);
	endtask : t_reset
	task t_req;
		req_i = 16'h0000;
		@(negedge ref_clk);
		check(chg_off, 1'b1);
		rdc(8'h14, 16'h0000);
		req_i = 16'hFFFF;
		@(negedge ref_clk);
		rdc(8'h14, 16'hFFFF);
		check(cv, 1'b1);
		req_v = 16'hFFFF;
		@(negedge ref_clk);
		rdc(8'h15, 16'hFFFF);
		check(cc, 1'b1);
		req_v = 16'h3138;
		req_i = 16'h05DC;
		@(negedge ref_clk);
		rdc(8'h15, 16'h3138);
		check({cc, chg_off}, 2'h0);
	endtask : t_req
	task t_err;
		logic [7:0] a[4];
		logic [2:0] e[4];
		a = '{8'h16, 8'h16, 8'h20, 8'h20};
		e = '{3'h4, 3'h6, 3'h3, 3'h3};
		for (int i = 0; i < 4; i++) begin
			if (i < 3) i_batt_host_model.write_word(a[i], i == 1);
			else rdc(a[i], 16'h0000);
			st(16'h0007, {13'h0000, e[i]});
			st(16'h0007, 16'h0000);
		end
	endtask : t_err
	task t_times;
		m.smoothed_current = -16'sd600;
		settle();
		rdc(8'h12, 16'h0064);
		rdc(8'h13, 16'hFFFF);
		c.low_runtime_threshold = 16'h00C8;
		st(16'h0100, 16'h0100);
		c.low_runtime_threshold = 16'h000A;
		st(16'h0100, 16'h0000);
		cap_mode = 1'b1;
		m.smoothed_power = -16'sd300;
		settle();
		rdc(8'h12, 16'h00C8);
		cap_mode = 1'b0;
		m.remaining_charge = 16'h07D0;
		m.smoothed_current = -16'sd1;
		settle();
		rdc(8'h12, 16'hFFFE);
		m.remaining_charge = 16'h03E8;
		m.charging = 1'b1;
		m.smoothed_current = 16'sd600;
		settle();
		rdc(8'h13, 16'h0064);
		rdc(8'h12, 16'hFFFF);
		st(16'h0040, 16'h0000);
		m.charging = 1'b0;
		m.smoothed_current = 16'sd0;
		st(16'h0040, 16'h0040);
	endtask : t_times
	task t_flags;
		m.charging = 1'b1;
		m.charge_percent_of_full = 8'h64;
		m.remaining_charge = 16'h0898;
		st(16'h8020, 16'h8020);
		m.remaining_charge = 16'h03E8;
		m.charging = 1'b0;
		pulse(1);
		st(16'h8000, 16'h8000);
		pulse(1);
		st(16'h8020, 16'h0020);
		m.charge_percent_of_full = 8'h32;
		st(16'h0020, 16'h0000);
		m.charging = 1'b1;
		pulse(0);
		st(16'h4000, 16'h4000);
		m.charging = 1'b0;
		st(16'h4000, 16'h0000);
		m.temperature = 16'sd60;
		st(16'h1000, 16'h1000);
		m.temperature = 16'sd56;
		st(16'h1000, 16'h1000);
		m.temperature = 16'sd54;
		st(16'h1000, 16'h0000);
		m.charging = 1'b1;
		m.temperature = 16'sd45;
		st(16'h1000, 16'h1000);
		m.temperature = 16'sd39;
		st(16'h1000, 16'h0000);
		m.charging = 1'b0;
		m.cell_undervoltage_flag = 1'b1;
		st(16'h0800, 16'h0800);
		m.cell_undervoltage_flag = 1'b0;
		st(16'h0800, 16'h0000);
		m.pack_voltage = 16'h2328;
		st(16'h0800, 16'h0800);
		m.pack_voltage = 16'h2EE0;
		st(16'h0800, 16'h0000);
		m.remaining_charge = 16'h0000;
		st(16'h0800, 16'h0800);
		m.remaining_charge = 16'h03E8;
		st(16'h0800, 16'h0000);
		c.low_charge_threshold = 16'h05DC;
		st(16'h0200, 16'h0200);
		c.low_charge_threshold = 16'h01F4;
		st(16'h0200, 16'h0000);
		pulse(2);
		st(16'h0080, 16'h0080);
		pulse(3);
		st(16'h0080, 16'h0000);
		m.charge_percent_of_full = 8'h03;
		st(16'h0010, 16'h0010);
		m.charge_percent_of_full = 8'h13;
		st(16'h0010, 16'h0010);
		m.charge_percent_of_full = 8'h14;
		st(16'h0010, 16'h0000);
		m.cell_undervoltage_flag = 1'b1;
		st(16'h0800, 16'h0800);
		pulse(4);
		check(msg_valid, 1'b1);
		check(msg, {d[15:3], 3'h7});
		@(negedge ref_clk);
		check(msg_valid, 1'b0);
	endtask : t_flags
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		srst = 1'b1;
		ev = 5'h00;
		cap_mode = 1'b0;
		req_i = 16'h05DC;
		req_v = 16'h3138;
		m = '{16'h03E8, 16'h07D0, 16'sd0, 16'sd0, 16'sd0, 16'h2EE0, 16'h0FA0, 16'sd25, 8'h32,
			1'b0, 1'b0};
		c = '{16'h0064, 16'h2328, -16'sd5, 16'sd45, 16'sd40, 16'sd60, 16'sd55, 16'h2710,
			16'h0BB8, 16'h1388, 8'h5F, 8'h05, 16'h0064, 16'h000A};
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		t_reset();
		t_req();
		t_err();
		t_times();
		t_flags();
		tally_and_finish();
	end
endmodule : tb
